// ---- ecc_consts.vh ----
// Constants for the NAND page error-correction control, mode and status block.
`ifndef ECC_CONSTS_VH
`define ECC_CONSTS_VH
`define OFF_CONTROL       8'h00
`define OFF_MODE          8'h04
`define OFF_STATUS_LOW    8'h08
`define OFF_PARITY_0      8'h0c
`define OFF_PARITY_1      8'h10
`define CTL_PARITY_CLR    0
`define CTL_SOFT_RESET    1
`define MODE_PAGE_LO      0
`define MODE_PAGE_HI      1
`define MODE_GRAN_LO      4
`define MODE_GRAN_HI      5
`define MODE_RESET        6'h00
`define GRAN_WHOLE        2'h0
`define GRAN_256          2'h1
`define GRAN_512          2'h2
`define PAGE_528          13'h0210
`define PAGE_1056         13'h0420
`define PAGE_2112         13'h0840
`define PAGE_4224         13'h1080
`define CMD_READ          8'h00
`define CMD_WRITE         8'h80
`define SECTORS           8
`define SEC_BYTES_256     13'h0100
`define SEC_BYTES_512     13'h0200
`define CODE_BITS         24
`define WHOLE_CODE_BITS   32
`endif

// ---- ecc_ctrl.v ----
// Top of the NAND page error-correction unit: registers, command watch and sector steering.
//
// How it works
// [R01] Control bit 0 written high clears all parity results; low does nothing.
// [R02] Control bit 1 written high soft-resets every register; low does nothing.
// [R03] Page size field picks 528, 1056, 2112 or 4224 words per page.
// [R04] Words are 8 or 16 bits wide, per the attached flash organisation.
// [R05] Granularity 00 computes one code over the whole page.
// [R06] Granularity 01 computes one code per 256-byte chunk.
// [R07] Granularity 10 computes one code per 512-byte chunk.
// [R08] Status holds per sector recoverable, check-code, multi flags at 4i; 4i+3 reserved.
// [R09] Recoverable flag set when a data error is detected in the sector (syndrome with more than one bit set).
// [R10] Check-code flag set when exactly one stored code bit is wrong.
// [R11] Sector 0 whole-page: bad bit in low 16 bits of parity 0 and 1.
// [R12] Sector 1 marks the bad bit in parity register 1; sectors 2 to 7 have no parity register.
// [R13] Multi-error flag set when more than one error is detected.
// [R14] Whole-page mode forces sector 1 to 7 flags to read zero.
// [R15] Sector i covers bytes 256i..256i+255 or 512i..512i+511.
// [R16] Computation starts on a detected read 00h or write 80h command.
// [R17] Status and parity clear on each new command or soft reset.
// [R18] Granularity 11 is reserved; software must not program it.
// [R19] Mode register: page size at bits 1:0, granularity at 5:4.
`timescale 1ns/1ns
`include "ecc_consts.vh"
module ecc_ctrl (
   input  wire        mclk_in,
   input  wire        rstn_in,
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [7:0]  paddr_in,
   input  wire [31:0] pwdata_in,
   output reg  [31:0] prdata_out,
   input  wire        cmd_strobe_in,
   input  wire        addr_strobe_in,
   input  wire        data_strobe_in,
   input  wire [15:0] flash_data_in,
   input  wire        wide_bus_in,
   output wire        busy_out
);
   // ==========================================================
   // Register access
   wire        wr_en = psel_in & penable_in & pwrite_in;
   wire        ctl_wr = wr_en && (paddr_in == `OFF_CONTROL);
   wire        soft_rst = ctl_wr & pwdata_in[`CTL_SOFT_RESET]; // [R02]
   wire        par_clr = ctl_wr & pwdata_in[`CTL_PARITY_CLR]; // [R01]
   wire        rst_all = ~rstn_in | soft_rst; // [R02]
   reg  [5:0]  mode_q;
   wire [1:0]  page_sel = mode_q[`MODE_PAGE_HI:`MODE_PAGE_LO];
   wire [1:0]  gran = mode_q[`MODE_GRAN_HI:`MODE_GRAN_LO];
   always @(posedge mclk_in) begin
      if (rst_all)
         mode_q <= `MODE_RESET;
      else if (wr_en && (paddr_in == `OFF_MODE))
         mode_q <= {pwdata_in[`MODE_GRAN_HI:`MODE_GRAN_LO], 2'h0,
                    pwdata_in[`MODE_PAGE_HI:`MODE_PAGE_LO]}; // [R19]
   end
   // ==========================================================
   // Command watch and page walk
   localparam ST_IDLE = 3'h1;
   localparam ST_MAIN = 3'h2;
   localparam ST_SPARE = 3'h4;
   reg  [2:0]  state_q;
   reg  [12:0] word_q;
   reg  [12:0] spare_q;
   reg  [12:0] page_words;
   wire        start = cmd_strobe_in &&
                       (flash_data_in[7:0] == `CMD_READ || flash_data_in[7:0] == `CMD_WRITE); // [R16]
   wire        new_cmd = cmd_strobe_in; // [R17]
   wire [12:0] main_words = page_words - (page_words >> 5);
   always @* begin
      case (page_sel) // [R03]
         2'h0: page_words = `PAGE_528;
         2'h1: page_words = `PAGE_1056;
         2'h2: page_words = `PAGE_2112;
         default: page_words = `PAGE_4224;
      endcase
   end
   // Byte position within the main area; a 16-bit word counts as two bytes.
   wire [12:0] byte_pos = wide_bus_in ? {word_q[11:0], 1'b0} : word_q; // [R04]
   reg  [2:0]  sector;
   reg  [11:0] widx;
   always @* begin
      case (gran)
         `GRAN_256: begin
            sector = byte_pos[10:8]; // [R06] [R15]
            widx   = {4'h0, byte_pos[7:0]};
         end
         `GRAN_512: begin
            sector = byte_pos[11:9]; // [R07] [R15]
            widx   = {3'h0, byte_pos[8:0]};
         end
         default: begin
            // Value 11 picks sector 0 here like whole-page, though the read mux treats it as a sector mode; its behaviour is undefined anyway.
            sector = 3'h0; // [R05] [R18]
            widx   = word_q[11:0];
         end
      endcase
   end
   wire        data_main = (state_q == ST_MAIN) & data_strobe_in;
   wire        data_spare = (state_q == ST_SPARE) & data_strobe_in;
   reg  [3:0]  nsec;
   always @* begin
      case (gran)
         `GRAN_256: nsec = main_words[12:8] > 5'h8 ? 4'h8 : {1'b0, main_words[10:8]};
         `GRAN_512: nsec = main_words[12:9] > 4'h8 ? 4'h8 : main_words[12:9];
         default:   nsec = 4'h1;
      endcase
   end
   // Stored codes are read back four bytes per sector after the main area.
   wire [12:0] spare_end = {7'h0, nsec, 2'h0};
   reg  [31:0] stored_q;
   wire [2:0]  chk_sec = spare_q[4:2];
   always @(posedge mclk_in) begin
      if (rst_all) begin
         state_q  <= ST_IDLE;
         word_q   <= 13'h0;
         spare_q  <= 13'h0;
         stored_q <= 32'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start) begin
                  state_q <= ST_MAIN; // [R16]
                  word_q  <= 13'h0;
               end
            end
            ST_MAIN: begin
               if (new_cmd && !start)
                  state_q <= ST_IDLE;
               else if (start)
                  word_q <= 13'h0;
               else if (data_main) begin
                  if (word_q + 13'h1 == main_words) begin
                     state_q <= ST_SPARE;
                     spare_q <= 13'h0;
                  end
                  word_q <= word_q + 13'h1;
               end
            end
            ST_SPARE: begin
               if (new_cmd) begin
                  state_q <= start ? ST_MAIN : ST_IDLE;
                  word_q  <= 13'h0;
               end else if (data_spare) begin
                  stored_q <= {flash_data_in[7:0], stored_q[31:8]};
                  spare_q  <= spare_q + 13'h1;
                  if (spare_q + 13'h1 == spare_end)
                     state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
   assign busy_out = (state_q != ST_IDLE);
   // ==========================================================
   // Sector accumulators
   wire [31:0] par [0:7];
   wire [7:0]  rec;
   wire [7:0]  cke;
   wire [7:0]  mul;
   wire        last_byte = data_spare && (spare_q[1:0] == 2'h3);
   reg         done_q;
   reg  [2:0]  done_sec_q;
   always @(posedge mclk_in) begin
      if (rst_all) begin
         done_q     <= 1'b0;
         done_sec_q <= 3'h0;
      end else begin
         done_q     <= last_byte;
         done_sec_q <= chk_sec;
      end
   end
   genvar g;
   generate
      for (g = 0; g < `SECTORS; g = g + 1) begin : sec
         sector_code u_code (
            .mclk_in         (mclk_in),
            .clr_in          (rst_all | new_cmd), // [R17]
            .data_en_in      (data_main && (sector == g)),
            .data_in         (flash_data_in),
            .word_idx_in     (widx),
            .wide_in         (wide_bus_in),
            .check_en_in     (last_byte && (chk_sec == g)),
            // A sector code holds only 24 bits, so its top byte is taken as matching.
            .stored_in       ({(gran == `GRAN_WHOLE) ? flash_data_in[7:0] : par[g][31:24],
                               stored_q[31:8]}),
            .check_done_in   (done_q && (done_sec_q == g)),
            .parity_out      (par[g]),
            .recoverable_out (rec[g]), // [R09]
            .checkcode_out   (cke[g]), // [R10]
            .multi_out       (mul[g]) // [R13]
         );
      end
   endgenerate
   // ==========================================================
   // Status and read mux
   reg  [31:0] status;
   reg  [31:0] pr0;
   reg  [31:0] pr1;
   integer     k;
   always @* begin
      status = 32'h0;
      for (k = 0; k < `SECTORS; k = k + 1) begin
         if (k == 0 || gran != `GRAN_WHOLE) begin // [R14]
            status[4*k]   = rec[k]; // [R08]
            status[4*k+1] = cke[k];
            status[4*k+2] = mul[k];
         end
      end
      if (gran == `GRAN_WHOLE) begin
         pr0 = {16'h0, par[0][15:0]}; // [R11]
         pr1 = {16'h0, par[0][31:16]};
      end else begin
         pr0 = {8'h0, par[0][`CODE_BITS-1:0]}; // [R11]
         pr1 = {8'h0, par[1][`CODE_BITS-1:0]}; // [R12]
      end
   end
   // Parity clear hides the results but keeps the status flags until the next command.
   reg         par_hold_q;
   always @(posedge mclk_in) begin
      if (par_clr)
         par_hold_q <= 1'b1; // [R01]
      else if (rst_all | new_cmd)
         par_hold_q <= 1'b0;
   end
   always @(posedge mclk_in) begin
      if (~rstn_in)
         prdata_out <= 32'h0;
      else if (psel_in && !pwrite_in) begin
         case (paddr_in)
            `OFF_MODE:       prdata_out <= {26'h0, mode_q};
            `OFF_STATUS_LOW: prdata_out <= status;
            `OFF_PARITY_0:   prdata_out <= par_hold_q ? 32'h0 : pr0; // [R01]
            `OFF_PARITY_1:   prdata_out <= par_hold_q ? 32'h0 : pr1;
            default:         prdata_out <= 32'h0;
         endcase
      end
   end
endmodule

// ---- ecc_ctrl_asserts.sv ----
// Port-level checker for the error-correction register block.
`timescale 1ns/1ns
module ecc_ctrl_asserts (
   input wire        mclk_in,
   input wire        rstn_in,
   input wire        psel_in,
   input wire        penable_in,
   input wire        pwrite_in,
   input wire [7:0]  paddr_in,
   input wire [31:0] pwdata_in,
   input wire [31:0] prdata_out,
   input wire        cmd_strobe_in,
   input wire [15:0] flash_data_in,
   input wire        busy_out
);
   // ========
   // Shadow of the mode register, so readback can be judged without the body.
   wire       rd = psel_in && !penable_in && !pwrite_in;
   wire       wr = psel_in && penable_in && pwrite_in;
   wire       rd_stat = rd && paddr_in == 8'h08;
   wire       rd_par = rd && (paddr_in == 8'h0c || paddr_in == 8'h10);
   wire       cmd = cmd_strobe_in && (flash_data_in[7:0] == 8'h00 || flash_data_in[7:0] == 8'h80);
   reg  [5:0] mode_q;
   always @(posedge mclk_in) begin
      if (!rstn_in || (wr && paddr_in == 8'h00 && pwdata_in[1]))
         mode_q <= 6'h00;
      else if (wr && paddr_in == 8'h04)
         mode_q <= pwdata_in[5:0] & 6'h33;
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   a_ctl_reads_zero: assert property (rd && paddr_in == 8'h00 |=> prdata_out == 32'h0)
      else $error("control read not zero");
   a_mode_readback: assert property (rd && paddr_in == 8'h04 |=> prdata_out == {26'h0, $past(mode_q)})
      else $error("mode readback wrong");
   a_status_reserved: assert property (rd_stat |=> (prdata_out & 32'h88888888) == 32'h0)
      else $error("reserved status bit set");
   a_whole_only_s0: assert property (rd_stat && mode_q[5:4] == 2'h0 |=> prdata_out[31:4] == 28'h0)
      else $error("upper sector flags in whole-page mode");
   a_multi_has_rec: assert property (rd_stat |=> ((prdata_out >> 2) & ~prdata_out & 32'h11111111) == 0)
      else $error("multi flag without recoverable flag");
   a_busy_on_cmd: assert property (cmd |=> busy_out)
      else $error("command did not start");
   a_soft_idle: assert property (wr && paddr_in == 8'h00 && pwdata_in[1] |=> !busy_out)
      else $error("soft reset left unit busy");
   a_parity_cleared: assert property (wr && paddr_in == 8'h00 && pwdata_in[0] ##[1:3] rd_par |=> prdata_out == 0)
      else $error("parity not cleared");
   a_cmd_clears: assert property (cmd ##[1:6] (rd_stat || rd_par) |=> prdata_out == 32'h0)
      else $error("results not cleared by command");
   c_error_seen: cover property (rd_stat ##1 prdata_out[2]);
   c_cmd_busy: cover property (cmd ##1 busy_out);
   c_soft_reset: cover property (wr && paddr_in == 8'h00 && pwdata_in[1]);
endmodule
bind ecc_ctrl ecc_ctrl_asserts i_chk (.mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .prdata_out(prdata_out), .cmd_strobe_in(cmd_strobe_in), .flash_data_in(flash_data_in), .busy_out(busy_out));

// ---- flash_stream_model.sv ----
// Flash-side traffic source: command, address and page bytes.
`timescale 1ns/1ns
module flash_stream_model (
   input  wire         mclk_in,
   output logic        cmd_strobe_out = 1'b0,
   output logic        addr_strobe_out = 1'b0,
   output logic        data_strobe_out = 1'b0,
   output logic [15:0] flash_data_out = 16'h0000
);
   // ========
   // Page image: 512 main bytes, then the stored codes.
   logic [7:0] mem [0:519];
   task send(input logic c, input logic a, input logic d, input logic [15:0] v);
      @(posedge mclk_in) #1;
      cmd_strobe_out = c;
      addr_strobe_out = a;
      data_strobe_out = d;
      flash_data_out = v;
   endtask
   // Bit indices f0 and f1 are flipped in flight; a value past the page means none.
   task page(input logic [7:0] cmd, input int n, input int f0, input int f1);
      logic [7:0] b;
      send(1'b1, 1'b0, 1'b0, {~cmd, cmd});
      if (n > 0)
         repeat (4) send(1'b0, 1'b1, 1'b0, 16'h0000);
      for (int k = 0; k < n; k++) begin
         b = mem[k];
         if (f0 / 8 == k) b[f0 % 8] = ~b[f0 % 8];
         if (f1 / 8 == k) b[f1 % 8] = ~b[f1 % 8];
         // The upper byte is not part of an 8-bit bus, so it carries junk.
         send(1'b0, 1'b0, 1'b1, {~b, b});
      end
      repeat (3) send(1'b0, 1'b0, 1'b0, ~flash_data_out);
   endtask
endmodule

// ---- nand_page_ecc_ctrl_status_tb_top.sv ----
// Self-checking bench for the error-correction register block.
`timescale 1ns/1ns
module nand_page_ecc_ctrl_status_tb_top;
   // ========
   // Stimulus and scoreboard.
   logic        mclk_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [7:0]  paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0, seed = 32'd52, v, code0, code1, r;
   logic [63:0] e;
   logic [63:0] exp_q[$];
   wire  [31:0] prdata_out;
   wire         cmd_s, addr_s, data_s, busy_out;
   wire  [15:0] fdata;
   int          fails = 0, n_compared = 0, cyc = 0;
   always #5 mclk_in = ~mclk_in;
   ecc_ctrl i_dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .cmd_strobe_in(cmd_s), .addr_strobe_in(addr_s), .data_strobe_in(data_s), .flash_data_in(fdata),
      .wide_bus_in(1'b0), .busy_out(busy_out));
   flash_stream_model i_flash (.mclk_in(mclk_in), .cmd_strobe_out(cmd_s), .addr_strobe_out(addr_s),
      .data_strobe_out(data_s), .flash_data_out(fdata));
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task print_verdict();
      $display("TB: fails=%0d compared=%0d", fails, n_compared);
      if (fails == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Mask m selects the bits judged on a read; zero means fetch only.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, output logic [31:0] q);
      @(posedge mclk_in) #1;
      psel_in = 1'b1;
      pwrite_in = w;
      paddr_in = a;
      pwdata_in = d;
      if (!w) exp_q.push_back({m, d});
      @(posedge mclk_in) #1;
      penable_in = 1'b1;
      @(posedge mclk_in);
      q = prdata_out;
      #1;
      psel_in = 1'b0;
      penable_in = 1'b0;
   endtask
   task chk(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, x, 32'hffffffff, r);
   endtask
   task wrt(input logic [7:0] a, input logic [31:0] x);
      apb(1'b1, a, x, 32'h0, r);
   endtask
   task run_gran(input logic [1:0] g, input int ns);
      wrt(8'h04, {26'h0, g, 4'h0});
      for (int k = 0; k < 512; k++) begin
         v = xs();
         i_flash.mem[k] = v[7:0];
      end
      i_flash.page(8'h80, 512, 9999, 9999);
      apb(1'b0, 8'h0c, 32'h0, 32'h0, code0);
      apb(1'b0, 8'h10, 32'h0, 32'h0, code1);
      if (g == 2'h0)
         code0 = {code1[15:0], code0[15:0]};
      for (int j = 0; j < 4; j++) begin
         i_flash.mem[512 + j] = code0[8 * j +: 8];
         i_flash.mem[516 + j] = code1[8 * j +: 8];
      end
      i_flash.page(8'h00, 512 + 4 * ns, 9999, 9999);
      chk(8'h08, 32'h0);
      i_flash.page(8'h00, 512 + 4 * ns, 2406, 9999);
      chk(8'h08, ns == 2 ? 32'h10 : 32'h01);
      i_flash.page(8'h00, 512 + 4 * ns, 4099, 9999);
      chk(8'h08, 32'h02);
      chk(8'h0c, 32'h8);
      i_flash.page(8'h00, 512 + 4 * ns, 40, 700);
      chk(8'h08, 32'h05);
      if (ns == 2) begin
         i_flash.page(8'h00, 520, 4128, 9999);
         chk(8'h08, 32'h20);
         chk(8'h10, 32'h1);
      end
   endtask
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         print_verdict();
      end
      if (psel_in && penable_in && !pwrite_in && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (e[63:32] != 32'h0) begin
            n_compared++;
            if ((prdata_out & e[63:32]) !== e[31:0]) begin
               fails++;
               $display("ERROR t=%0t got=%h exp=%h", $time, prdata_out, e[31:0]);
            end
         end
      end
   end
   initial begin
      repeat (20) @(posedge mclk_in);
      #1 rstn_in = 1'b1;
      for (int a = 0; a < 24; a += 4)
         chk(a[7:0], 32'h0);
      for (int i = 0; i < 4; i++) begin
         v = xs() & 32'hffffffdf;
         v[1:0] = i[1:0];
         wrt(8'h04, v);
         chk(8'h04, v & 32'h33);
      end
      run_gran(2'h0, 1);
      run_gran(2'h2, 1);
      run_gran(2'h1, 2);
      i_flash.page(8'h00, 0, 9999, 9999);
      chk(8'h08, 32'h0);
      i_flash.page(8'h00, 520, 2406, 9999);
      wrt(8'h00, 32'h1);
      chk(8'h0c, 32'h0);
      chk(8'h04, 32'h10);
      wrt(8'h00, 32'h0);
      chk(8'h08, 32'h10);
      wrt(8'h00, 32'h2);
      chk(8'h04, 32'h0);
      chk(8'h08, 32'h0);
      print_verdict();
   end
endmodule

// ---- sector_code.v ----
// One sector's running parity accumulator and syndrome classifier.
`timescale 1ns/1ns
`include "ecc_consts.vh"
module sector_code (
   input  wire        mclk_in,
   input  wire        clr_in,
   input  wire        data_en_in,
   input  wire [15:0] data_in,
   input  wire [11:0] word_idx_in,
   input  wire        wide_in,
   input  wire        check_en_in,
   input  wire [31:0] stored_in,
   input  wire        check_done_in,
   output reg  [31:0] parity_out,
   output reg         recoverable_out,
   output reg         checkcode_out,
   output reg         multi_out
);
   // Column pairs sit in bits 5:0 and line pairs from bit 6 up, so a 24-bit code
   // still covers every address bit of a 512-byte sector.
   // Every pair but bits 31:30 on an 8-bit bus is complementary: one flipped data bit flips exactly one half of it.
   reg  [31:0] acc_q;
   reg  [31:0] syn_q;
   wire        dpar  = wide_in ? ^data_in : ^data_in[7:0];
   wire [7:0]  cols  = data_in[7:0] ^ (wide_in ? data_in[15:8] : 8'h00);
   reg  [31:0] upd;
   reg         dbl;
   integer     i;
   always @* begin
      upd = 32'h0;
      dbl = 1'b0;
      upd[0] = ^(cols & 8'haa);
      upd[1] = ^(cols & 8'h55);
      upd[2] = ^(cols & 8'hcc);
      upd[3] = ^(cols & 8'h33);
      upd[4] = ^(cols & 8'hf0);
      upd[5] = ^(cols & 8'h0f);
      for (i = 0; i < 12; i = i + 1) begin
         upd[6+2*i] = dpar & word_idx_in[i];
         upd[7+2*i] = dpar & ~word_idx_in[i];
      end
      upd[30] = wide_in & ^data_in[15:8];
      upd[31] = wide_in & ^data_in[7:0];
      // Two flipped bits always set both halves of some pair.
      for (i = 0; i < 16; i = i + 1)
         dbl = dbl | (syn_q[2*i] & syn_q[2*i+1]);
   end
   always @(posedge mclk_in) begin
      if (clr_in) begin
         acc_q           <= 32'h0;
         syn_q           <= 32'h0;
         parity_out      <= 32'h0;
         recoverable_out <= 1'b0;
         checkcode_out   <= 1'b0;
         multi_out       <= 1'b0;
      end else begin
         if (data_en_in) begin
            acc_q      <= acc_q ^ upd;
            parity_out <= acc_q ^ upd;
         end
         if (check_en_in)
            syn_q <= acc_q ^ stored_in;
         if (check_done_in) begin
            parity_out      <= (syn_q == 32'h0) ? acc_q : syn_q;
            // A syndrome with one set bit points into the stored code, not the data.
            checkcode_out   <= (syn_q != 32'h0) && ((syn_q & (syn_q - 32'h1)) == 32'h0);
            recoverable_out <= (syn_q != 32'h0) && !((syn_q & (syn_q - 32'h1)) == 32'h0);
            multi_out       <= (syn_q != 32'h0) && dbl &&
                               !((syn_q & (syn_q - 32'h1)) == 32'h0);
         end
      end
   end
endmodule
